// File: dtc_timer.sv
`timescale 1ns/1ps
module dtc_timer
	import dtc_pkg::*;
(
	// Clock, reset and clock enable.
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Mode select register, one nibble per timer.
	input wire dtc_cfg_type cfg_first,
	input wire dtc_cfg_type cfg_second,
	// Run bits.
	input wire logic first_run_bit,
	input wire logic second_run_bit,
	// Clock choice register bits.
	input wire logic first_sysclk_select,
	input wire logic second_sysclk_select,
	input wire logic [1:0] divider_select,
	// Gating polarity register bits.
	input wire logic first_gating_polarity,
	input wire logic second_gating_polarity,
	// Interrupt mask bits.
	input wire logic first_timer_irq_mask,
	input wire logic second_timer_irq_mask,
	// Software flag clears, one-cycle pulses.
	input wire logic first_flag_clear,
	input wire logic second_flag_clear,
	// Software byte loads.
	input wire dtc_load_type load,
	// External pins.
	input wire logic first_event_pin,
	input wire logic second_event_pin,
	input wire logic first_gating_input,
	input wire logic second_gating_input,
	input wire logic ext_clk_pin,
	// Count bytes.
	output logic [7:0] low_byte_first,
	output logic [7:0] high_byte_first,
	output logic [7:0] low_byte_second,
	output logic [7:0] high_byte_second,
	// Flags, interrupts and overflow tick.
	output logic first_overflow_flag,
	output logic second_overflow_flag,
	output logic first_timer_irq,
	output logic second_timer_irq,
	output logic second_overflow_tick
);
	logic rst_s1_reg, rst_s2_reg;
	logic rst_core_n;
	logic [DTC_PIN_COUNT-1:0] pins_raw, pins_level, pins_fall;
	logic presc_tick;

	logic [7:0] lo0_reg, hi0_reg, lo1_reg, hi1_reg;
	logic [7:0] lo0_next, hi0_next, lo1_next, hi1_next;
	logic f0_reg, f1_reg, f0_next, f1_next;
	logic irq0_reg, irq1_reg, irq0_next, irq1_next;
	logic tick1_reg, tick1_next;

	logic split;
	logic t0_src, t0_en;
	logic t1_src, t1_en;
	logic th_src, th_en;
	logic ovh;
	dtc_step_type st0, st1;

	// One count step of a timer in its mode; split mode counts the low byte only.
	function automatic dtc_step_type dtc_step(input logic [1:0] mode,
		input logic [7:0] lo, input logic [7:0] hi);
		dtc_step_type r;
		logic [12:0] c13;
		logic [15:0] c16;
		r.ovf = 1'b0;
		r.high = hi;
		r.low = lo;
		c13 = {hi, lo[DTC_LOW5_MSB:0]};
		c16 = {hi, lo};
		unique case (mode)
			DTC_MODE_13BIT: begin
				r.ovf = (c13 == DTC_13BIT_MAX); // RL4
				c13 = c13 + 13'h0001; // RL3
				r.high = c13[12:5]; // RL3
				r.low = {lo[7:5], c13[DTC_LOW5_MSB:0]}; // RL3
			end
			DTC_MODE_16BIT: begin
				r.ovf = (c16 == DTC_16BIT_MAX); // RL12
				c16 = c16 + 16'h0001; // RL12
				r.high = c16[15:8];
				r.low = c16[7:0];
			end
			DTC_MODE_RELOAD: begin
				r.ovf = (lo == DTC_BYTE_MAX); // RL13
				r.low = r.ovf ? hi : lo + 8'h01; // RL13
			end
			DTC_MODE_SPLIT: begin
				r.ovf = (lo == DTC_BYTE_MAX); // RL15
				r.low = lo + 8'h01; // RL15
			end
		endcase
		return r;
	endfunction

	// Reset release through two flops; the assertion stays asynchronous.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	assign rst_core_n = rst_s2_reg;

	// All external pins pass through the synchroniser.
	assign pins_raw[DTC_PIN_EV0] = first_event_pin;
	assign pins_raw[DTC_PIN_EV1] = second_event_pin;
	assign pins_raw[DTC_PIN_GT0] = first_gating_input;
	assign pins_raw[DTC_PIN_GT1] = second_gating_input;
	assign pins_raw[DTC_PIN_EXT] = ext_clk_pin;

	dtc_pin_sync #(
		.W(DTC_PIN_COUNT)
	) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_core_n),
		.ce(ce),
		.din(pins_raw),
		.level(pins_level),
		.fall(pins_fall)
	);

	// Shared divided clock for both timers and the split high byte.
	dtc_prescaler u_presc (
		.clk_sys(clk_sys),
		.rst_n(rst_core_n),
		.ce(ce),
		.divider_select(divider_select),
		.ext_fall(pins_fall[DTC_PIN_EXT]),
		.tick(presc_tick)
	);

	// Count sources and enables for each counter.
	always_comb begin
		split = (cfg_first.mode == DTC_MODE_SPLIT); // RL15
		// Event pin or timer clock for the first timer.
		if (cfg_first.count_event_select) begin
			t0_src = pins_fall[DTC_PIN_EV0]; // RL6
		end else begin
			t0_src = first_sysclk_select | presc_tick; // RL7
		end
		t0_en = first_run_bit & (~cfg_first.pin_gating |
			(pins_level[DTC_PIN_GT0] == first_gating_polarity)); // RL8 RL9
		// The second timer loses its external clock while the first is split.
		if (cfg_second.count_event_select && !split) begin
			t1_src = pins_fall[DTC_PIN_EV1]; // RL6
		end else begin
			t1_src = second_sysclk_select | presc_tick; // RL7 RL17
		end
		if (cfg_second.mode == DTC_MODE_SPLIT) begin
			t1_en = 1'b0; // RL19
		end else if (split) begin
			t1_en = 1'b1; // RL19
		end else begin
			t1_en = second_run_bit & (~cfg_second.pin_gating |
				(pins_level[DTC_PIN_GT1] == second_gating_polarity)); // RL8 RL9
		end
		// Split high byte is timer-only, run by the second run bit.
		th_src = first_sysclk_select | presc_tick; // RL16
		th_en = split & second_run_bit; // RL16
	end

	// Next count, flag and output values.
	always_comb begin
		lo0_next = lo0_reg;
		hi0_next = hi0_reg;
		lo1_next = lo1_reg;
		hi1_next = hi1_reg;
		f0_next = f0_reg;
		f1_next = f1_reg;
		irq0_next = irq0_reg;
		irq1_next = irq1_reg;
		tick1_next = tick1_reg;
		st0 = dtc_step(cfg_first.mode, lo0_reg, hi0_reg);
		st1 = dtc_step(cfg_second.mode, lo1_reg, hi1_reg);
		ovh = 1'b0;
		if (ce) begin
			st0.ovf = st0.ovf & t0_en & t0_src;
			st1.ovf = st1.ovf & t1_en & t1_src;
			// Counting only advances the bytes; run never touches them.
			if (t0_en && t0_src) begin
				lo0_next = st0.low; // RL10 RL1
				hi0_next = split ? hi0_reg : st0.high; // RL2
			end
			if (th_en && th_src) begin
				ovh = (hi0_reg == DTC_BYTE_MAX); // RL16
				hi0_next = hi0_reg + 8'h01; // RL16
			end
			if (t1_en && t1_src) begin
				lo1_next = st1.low; // RL1
				hi1_next = st1.high; // RL2
			end
			// Software loads take priority over a same-cycle count.
			if (load.low_byte_first) begin
				lo0_next = load.data;
			end
			if (load.high_byte_first) begin
				hi0_next = load.data;
			end
			if (load.low_byte_second) begin
				lo1_next = load.data;
			end
			if (load.high_byte_second) begin
				hi1_next = load.data;
			end
			// Hardware set wins over a same-cycle clear.
			f0_next = (f0_reg & ~first_flag_clear) | st0.ovf; // RL4 RL13
			f1_next = (f1_reg & ~second_flag_clear) |
				(split ? ovh : st1.ovf); // RL16 RL17
			irq0_next = f0_next & first_timer_irq_mask; // RL5
			irq1_next = f1_next & second_timer_irq_mask; // RL5
			tick1_next = st1.ovf; // RL18
		end
	end

	// State registers.
	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			lo0_reg <= DTC_BYTE_RESET;
			hi0_reg <= DTC_BYTE_RESET;
			lo1_reg <= DTC_BYTE_RESET;
			hi1_reg <= DTC_BYTE_RESET;
			f0_reg <= 1'b0;
			f1_reg <= 1'b0;
			irq0_reg <= 1'b0;
			irq1_reg <= 1'b0;
			tick1_reg <= 1'b0;
		end else begin
			lo0_reg <= lo0_next;
			hi0_reg <= hi0_next;
			lo1_reg <= lo1_next;
			hi1_reg <= hi1_next;
			f0_reg <= f0_next;
			f1_reg <= f1_next;
			irq0_reg <= irq0_next;
			irq1_reg <= irq1_next;
			tick1_reg <= tick1_next;
		end
	end

	// Outputs come straight from the state flops.
	assign low_byte_first = lo0_reg;
	assign high_byte_first = hi0_reg;
	assign low_byte_second = lo1_reg;
	assign high_byte_second = hi1_reg;
	assign first_overflow_flag = f0_reg;
	assign second_overflow_flag = f1_reg;
	assign first_timer_irq = irq0_reg;
	assign second_timer_irq = irq1_reg;
	assign second_overflow_tick = tick1_reg;
endmodule

// File: dtc_pkg.sv
// What this block does
// [RL1] Each timer is a 16-bit count held as separate low and high bytes.
// [RL2] Each timer has its own two mode bits, configured independently.
// [RL3] Mode 0 is 13-bit: high byte plus low-byte bits 4..0; bits 7..5 undefined.
// [RL4] A 13-bit wrap from all ones to zero sets that timer's overflow flag.
// [RL5] Interrupt request is overflow flag and that timer's mask bit.
// [RL6] With event select set, each falling edge on the event pin increments.
// [RL7] Otherwise count on system clock or the divided clock per sysclk select.
// [RL8] Count only while run is set and gating is off or gate input active.
// [RL9] Gate inputs are active at the level set by their polarity bits.
// [RL10] Setting run never clears or presets the count.
// [RL11] Software loads the count before run and ignores undefined low bits.
// [RL12] Mode 1 equals mode 0 but uses all sixteen bits.
// [RL13] Mode 2 counts low byte, on wrap sets flag and reloads from high byte.
// [RL14] Software sets the low byte before enabling auto-reload mode.
// [RL15] Mode 3 splits the first timer; low byte uses first timer's controls.
// [RL16] Split high byte is a clock-only timer run by second run bit, sets second flag.
// [RL17] During split, second timer counts but no external clock, flag or interrupt.
// [RL18] Second timer overflow is always an output tick, split mode included.
// [RL19] During split, second timer runs in modes 0..2 and stops in mode 3.
// [RL20] Event pins hold each level two cycles; events up to a quarter clock rate.
// [RL21] Divider code 00 is /12, 01 and 10 are /4, 11 is external clock /8.
// [RL22] Event and gate pins are synchronised; each falling event edge gives one pulse.
package dtc_pkg;
	localparam logic [1:0] DTC_MODE_13BIT = 2'h0;
	localparam logic [1:0] DTC_MODE_16BIT = 2'h1;
	localparam logic [1:0] DTC_MODE_RELOAD = 2'h2;
	localparam logic [1:0] DTC_MODE_SPLIT = 2'h3;
	localparam logic [1:0] DTC_DIV_SYS12 = 2'h0;
	localparam logic [1:0] DTC_DIV_SYS4A = 2'h1;
	localparam logic [1:0] DTC_DIV_SYS4B = 2'h2;
	localparam logic [1:0] DTC_DIV_EXT8 = 2'h3;
	localparam logic [3:0] DTC_SYS12_COUNT = 4'hc;
	localparam logic [3:0] DTC_SYS4_COUNT = 4'h4;
	localparam logic [3:0] DTC_EXT8_COUNT = 4'h8;
	localparam logic [3:0] DTC_PRESC_RESET = 4'h0;
	localparam logic [7:0] DTC_BYTE_RESET = 8'h00;
	localparam logic [7:0] DTC_BYTE_MAX = 8'hff;
	localparam logic [12:0] DTC_13BIT_MAX = 13'h1fff;
	localparam logic [15:0] DTC_16BIT_MAX = 16'hffff;
	localparam int DTC_LOW5_MSB = 4;
	localparam int DTC_PIN_EV0 = 0;
	localparam int DTC_PIN_EV1 = 1;
	localparam int DTC_PIN_GT0 = 2;
	localparam int DTC_PIN_GT1 = 3;
	localparam int DTC_PIN_EXT = 4;
	localparam int DTC_PIN_COUNT = 5;

	// Per-timer nibble of the mode select register.
	typedef struct packed {
		logic pin_gating;
		logic count_event_select;
		logic [1:0] mode;
	} dtc_cfg_type;

	// Software byte loads into the count registers.
	typedef struct packed {
		logic low_byte_first;
		logic high_byte_first;
		logic low_byte_second;
		logic high_byte_second;
		logic [7:0] data;
	} dtc_load_type;

	// One timer's result after a count step.
	typedef struct packed {
		logic ovf;
		logic [7:0] high;
		logic [7:0] low;
	} dtc_step_type;
endpackage

// File: dtc_pin_sync.sv
`timescale 1ns/1ps
module dtc_pin_sync
	import dtc_pkg::*;
#(
	parameter int W = 5
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Raw pins and their synchronised forms.
	input wire logic [W-1:0] din,
	output logic [W-1:0] level,
	output logic [W-1:0] fall
);
	logic [W-1:0] s1_reg, s2_reg, s3_reg;
	logic [W-1:0] s1_next, s2_next, s3_next;

	// Two-flop synchroniser followed by one delay stage for edge detection.
	// A pin level held one cycle reaches the second stage two cycles later. RL20
	always_comb begin
		s1_next = ce ? din : s1_reg;
		s2_next = ce ? s1_reg : s2_reg;
		s3_next = ce ? s2_reg : s3_reg;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
		end
	end

	// Level and falling edge use only the second and third stages.
	assign level = s2_reg; // RL22
	assign fall = s3_reg & ~s2_reg; // RL22
endmodule

// File: dtc_prescaler.sv
`timescale 1ns/1ps
module dtc_prescaler
	import dtc_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Divider choice and external clock edges.
	input wire logic [1:0] divider_select,
	input wire logic ext_fall,
	output logic tick
);
	logic [3:0] cnt_reg, cnt_next;
	logic tick_reg, tick_next;
	logic [3:0] limit;
	logic step;

	// Divide ratio and the event that advances the divider.
	always_comb begin
		unique case (divider_select)
			DTC_DIV_SYS12: limit = DTC_SYS12_COUNT; // RL21
			DTC_DIV_SYS4A, DTC_DIV_SYS4B: limit = DTC_SYS4_COUNT; // RL21
			DTC_DIV_EXT8: limit = DTC_EXT8_COUNT; // RL21
		endcase
		step = (divider_select == DTC_DIV_EXT8) ? ext_fall : 1'b1;
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (ce && step) begin
			if (cnt_reg >= limit - 4'h1) begin
				cnt_next = DTC_PRESC_RESET;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 4'h1;
			end
		end else if (ce) begin
			tick_next = 1'b0;
		end else begin
			tick_next = tick_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= DTC_PRESC_RESET;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

// File: dtc_timer_chk.sv
`timescale 1ns/1ps
module dtc_timer_chk
	import dtc_pkg::*;
(
	// Clock, reset and enable.
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Controls.
	input wire dtc_cfg_type cfg_first,
	input wire logic first_run_bit,
	input wire logic second_run_bit,
	input wire logic first_timer_irq_mask,
	input wire dtc_load_type load,
	// Results.
	input wire logic [7:0] low_byte_first,
	input wire logic [7:0] high_byte_first,
	input wire logic first_overflow_flag,
	input wire logic second_overflow_flag,
	input wire logic first_timer_irq
);
	// All checks sample the system clock and rest while reset is low.
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_irq_tracks_flag: assert property (
		$past(ce) && $past(first_timer_irq_mask) |-> first_timer_irq == first_overflow_flag)
		else $error("irq differs from flag");
	a_wrap_sixteen: assert property (
		$rose(first_overflow_flag) && $past(cfg_first.mode) == DTC_MODE_16BIT |->
		{high_byte_first, low_byte_first} == 16'h0000) else $error("16-bit wrap not at zero");
	a_wrap_thirteen: assert property (
		$rose(first_overflow_flag) && $past(cfg_first.mode) == DTC_MODE_13BIT |->
		high_byte_first == 8'h00 && low_byte_first[4:0] == 5'h00) else $error("13-bit wrap not at zero");
	a_reload_value: assert property (
		$rose(first_overflow_flag) && $past(cfg_first.mode) == DTC_MODE_RELOAD |->
		low_byte_first == high_byte_first) else $error("reload value wrong");
	a_reload_keeps_high: assert property (
		$past(cfg_first.mode) == DTC_MODE_RELOAD && !$past(load.high_byte_first) |->
		$stable(high_byte_first)) else $error("reload byte changed");
	a_stopped_low_holds: assert property (
		!$past(first_run_bit) && !$past(load.low_byte_first) |-> $stable(low_byte_first))
		else $error("count moved while stopped");
	a_split_high_holds: assert property (
		$past(cfg_first.mode) == DTC_MODE_SPLIT && !$past(second_run_bit) && !$past(load.high_byte_first)
		|-> $stable(high_byte_first)) else $error("split high byte ran unstarted");
	a_split_sets_second: assert property (
		$rose(second_overflow_flag) && $past(cfg_first.mode) == DTC_MODE_SPLIT |->
		high_byte_first == 8'h00 && $past(high_byte_first) == 8'hff) else $error("second flag bad source");
	a_start_keeps_count: assert property (
		$rose(first_run_bit) && cfg_first.mode == DTC_MODE_16BIT && !load.low_byte_first |=>
		8'(low_byte_first - $past(low_byte_first)) <= 8'h01) else $error("start altered count");
endmodule
bind dtc_timer dtc_timer_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cfg_first(cfg_first),
	.first_run_bit(first_run_bit), .second_run_bit(second_run_bit), .load(load),
	.first_timer_irq_mask(first_timer_irq_mask), .low_byte_first(low_byte_first),
	.high_byte_first(high_byte_first), .first_overflow_flag(first_overflow_flag),
	.second_overflow_flag(second_overflow_flag), .first_timer_irq(first_timer_irq));

// File: dtc_pin_model.sv
`timescale 1ns/1ps
module dtc_pin_model
	import dtc_pkg::*;
(
	// Clock.
	input wire logic clk_sys,
	// Event enables and pin levels.
	input wire logic [1:0] ev_en,
	output logic [1:0] ev_pin,
	output logic ext_clk_pin
);
	logic [1:0] cnt [2] = '{2'h0, 2'h0};
	int ph = 0;
	initial ev_pin = 2'h3;
	initial ext_clk_pin = 1'b1;
	// Event pins idle high; enabled, each level lasts two cycles, one fall per four cycles.
	// Pins change by non-blocking assignment on the edge, so the enables are never raced.
	always @(posedge clk_sys) begin
		for (int i = 0; i < 2; i++) begin
			cnt[i] <= ev_en[i] ? cnt[i] + 2'h1 : 2'h0;
			ev_pin[i] <= ev_en[i] ? !cnt[i][1] : 1'b1;
		end
		ph <= (ph + 1) % 6;
		ext_clk_pin <= (ph < 3);
	end
endmodule

// File: dtc_timer_test.sv
`timescale 1ns/1ps
module dtc_timer_test
	import dtc_pkg::*;
;
	typedef struct {
		logic [1:0] m;
		logic [7:0] h, l;
		int n;
		logic [7:0] eh, el;
		logic ef;
	} dtc_row_type;
	dtc_row_type rows[5] = '{
		'{DTC_MODE_16BIT, 8'hff, 8'hfe, 3, 8'h00, 8'h01, 1'b1},
		'{DTC_MODE_13BIT, 8'hff, 8'hfe, 3, 8'h00, 8'h01, 1'b1},
		'{DTC_MODE_13BIT, 8'h00, 8'h1f, 1, 8'h01, 8'h00, 1'b0},
		'{DTC_MODE_RELOAD, 8'hf0, 8'hfe, 3, 8'hf0, 8'hf1, 1'b1},
		'{DTC_MODE_16BIT, 8'h12, 8'h34, 5, 8'h12, 8'h39, 1'b0}};
	// Ticks per count; the external clock has a six-cycle period.
	int div_len[4] = '{12, 4, 4, 48};
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	dtc_cfg_type c1 = '{1'b0, 1'b0, DTC_MODE_16BIT};
	dtc_cfg_type c2 = '{1'b0, 1'b0, DTC_MODE_SPLIT};
	dtc_load_type ld_r = '0;
	logic [1:0] r = 2'h0, s = 2'h3, dv = 2'h0, fc = 2'h0, evr = 2'h0, ev;
	logic pol = 1'b1, g = 1'b1, cen = 1'b1, ext, f1, f2, i1, i2, tk;
	logic [7:0] lo1, hi1, lo2, hi2;
	int num_errors = 0, checks_done = 0, tks = 0;
	// Clock at 40 MHz.
	always #12.5 clk_sys = ~clk_sys;
	// Counts second-timer overflow pulses.
	always @(posedge clk_sys) if (tk === 1'b1) tks++;
	dtc_pin_model pins_u (.clk_sys(clk_sys), .ev_en(evr), .ev_pin(ev), .ext_clk_pin(ext));
	dtc_timer dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(cen), .cfg_first(c1), .cfg_second(c2),
		.first_run_bit(r[0]), .second_run_bit(r[1]), .first_sysclk_select(s[0]),
		.second_sysclk_select(s[1]), .divider_select(dv), .first_gating_polarity(pol),
		.second_gating_polarity(1'b1), .first_timer_irq_mask(1'b1), .second_timer_irq_mask(1'b1),
		.first_flag_clear(fc[0]), .second_flag_clear(fc[1]), .load(ld_r),
		.first_event_pin(ev[0]), .second_event_pin(ev[1]), .first_gating_input(g),
		.second_gating_input(1'b0), .ext_clk_pin(ext), .low_byte_first(lo1), .high_byte_first(hi1),
		.low_byte_second(lo2), .high_byte_second(hi2), .first_overflow_flag(f1),
		.second_overflow_flag(f2), .first_timer_irq(i1), .second_timer_irq(i2),
		.second_overflow_tick(tk));
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// One byte load, optionally with flag clears, then an idle cycle.
	task ld(input logic [3:0] sel, input logic [7:0] d, input logic [1:0] clr);
		ld_r = {sel, d};
		fc = clr;
		tick(1);
		ld_r = '0;
		fc = 2'h0;
		tick(1);
	endtask
	task load1(input logic [7:0] h, input logic [7:0] l);
		ld(4'h4, h, 2'h3);
		ld(4'h8, l, 2'h0);
	endtask
	// Runs the first timer for exactly n clock edges.
	task run(input int n);
		r[0] = 1'b1;
		tick(n);
		r[0] = 1'b0;
		tick(1);
	endtask
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		tick(20);
		rst_n = 1'b1;
		tick(3);
		cmp({hi1, lo1, hi2, lo2} == 32'h0, 1'b1);
		cmp({f1, f2, i1, i2}, 4'h0);
		$display("reset done");
		foreach (rows[k]) begin
			c1.mode = rows[k].m;
			load1(rows[k].h, rows[k].l);
			run(rows[k].n);
			cmp(hi1, rows[k].eh);
			cmp(lo1 & (rows[k].m == DTC_MODE_13BIT ? 8'h1f : 8'hff), rows[k].el);
			cmp({f1, i1}, {2{rows[k].ef}});
		end
		$display("modes done");
		c1 = '{1'b1, 1'b0, DTC_MODE_16BIT};
		for (int p = 0; p < 2; p++) begin
			pol = p[0];
			g = !p[0];
			load1(8'h00, 8'h00);
			tick(4);
			run(5);
			cmp(lo1, 8'h00);
			g = p[0];
			tick(4);
			run(5);
			cmp(lo1, 8'h05);
		end
		$display("gating done");
		c1 = '{1'b0, 1'b1, DTC_MODE_16BIT};
		load1(8'h00, 8'h00);
		r[0] = 1'b1;
		evr = 2'h1;
		tick(16);
		evr = 2'h0;
		tick(8);
		r[0] = 1'b0;
		tick(1);
		cmp({hi1, lo1}, 16'h0004);
		c2 = '{1'b0, 1'b1, DTC_MODE_16BIT};
		ld(4'h2, 8'h00, 2'h3);
		ld(4'h1, 8'h00, 2'h0);
		r[1] = 1'b1;
		evr = 2'h2;
		tick(16);
		evr = 2'h0;
		tick(8);
		r[1] = 1'b0;
		tick(1);
		cmp({hi2, lo2}, 16'h0004);
		c2 = '{1'b0, 1'b0, DTC_MODE_SPLIT};
		$display("events done");
		c1 = '{1'b0, 1'b0, DTC_MODE_16BIT};
		s = 2'h2;
		for (int d = 0; d < 4; d++) begin
			dv = d[1:0];
			load1(8'h00, 8'h00);
			tick(120);
			run(10 * div_len[d]);
			cmp({hi1, lo1}, 16'h000a);
		end
		$display("divider done");
		c1 = '{1'b0, 1'b0, DTC_MODE_SPLIT};
		s = 2'h3;
		load1(8'hfe, 8'h55);
		ld(4'h2, 8'hfd, 2'h3);
		ld(4'h1, 8'hff, 2'h0);
		tks = 0;
		c2.mode = DTC_MODE_16BIT;
		tick(3);
		c2.mode = DTC_MODE_SPLIT;
		tick(2);
		cmp({hi2, lo2}, 16'h0000);
		cmp({f2, i2, tks[3:0]}, 6'h01);
		r[1] = 1'b1;
		tick(3);
		r[1] = 1'b0;
		tick(2);
		cmp({hi1, lo1}, 16'h0155);
		cmp({f2, i2, tks[3:0]}, 6'h31);
		cmp({hi2, lo2}, 16'h0000);
		run(2);
		cmp({hi1, lo1}, 16'h0157);
		$display("split done");
		// Clock enable low freezes the count even with run set.
		c1 = '{1'b0, 1'b0, DTC_MODE_16BIT};
		load1(8'h00, 8'h00);
		r[0] = 1'b1;
		cen = 1'b0;
		tick(5);
		cmp({hi1, lo1}, 16'h0000);
		cen = 1'b1;
		tick(5);
		r[0] = 1'b0;
		tick(1);
		cmp({hi1, lo1}, 16'h0005);
		$display("enable done");
		// Reset with the timer stopped clears the count, and loads work again after release.
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(3);
		cmp({hi1, lo1}, 16'h0000);
		cmp({f1, f2, i1, i2}, 4'h0);
		load1(8'h12, 8'h34);
		cmp({hi1, lo1}, 16'h1234);
		$display("second reset done");
		give_verdict;
	end
	// Cuts a hang short well past the roughly 1400 cycles the tests need.
	initial begin
		#(25 * 8000);
		num_errors++;
		give_verdict;
	end
endmodule
